// *** hdl/acs_analog_cmd_sel.sv ***
// analog command selection and sign logic with axi4-lite registers
`timescale 1ns/100ps
`include "acs_params.svh"
// Overview of operation
// - analog limit modes 0 and 4 give separate positive and negative torque limits
// - mode 0: positive limit from positive input, negative limit from negative input
// - modes 1, 2, 3, 6: analog limits ignored, parameter limits used
// - mode 4: both inputs positive range; mode 5: positive input sets both
// - speed selection 0 takes speed command from analog speed input
// - direction select 0: voltage sign gives direction, invert flips, sign pin ignored
// - direction select 1: speed sign pin gives direction, polarity and invert ignored
// - torque input select 0 takes torque input, 1 takes the alternate input
// - torque direction 0: voltage sign gives direction, invert flips, pin ignored
// - torque direction 1: torque sign pin gives direction only
// - torque command select 1 reads speed limit from analog speed limit input
module acs_analog_cmd_sel
  import acs_pkg::*;
#(
  parameter int W = 16
) (
  input  wire  logic                aclk,
  input  wire  logic                aresetn,
  input  wire  logic                ce,
  input  wire  logic signed [W-1:0] pos_torque_limit_in,
  input  wire  logic signed [W-1:0] neg_torque_limit_in,
  input  wire  logic signed [W-1:0] speed_cmd_analog_in,
  input  wire  logic signed [W-1:0] torque_cmd_analog_in,
  input  wire  logic signed [W-1:0] speed_limit_analog_in,
  input  wire  logic                speed_sign_in,
  input  wire  logic                torque_sign_in,
  output logic        [W-1:0]       pos_torque_limit,
  output logic        [W-1:0]       neg_torque_limit,
  output logic signed [W-1:0]       speed_cmd,
  output logic signed [W-1:0]       torque_cmd,
  output logic        [W-1:0]       speed_limit,
  output logic                      speed_from_analog,
  input  wire  logic [3:0]          s_axi_awaddr,
  input  wire  logic                s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire  logic [31:0]         s_axi_wdata,
  input  wire  logic [3:0]          s_axi_wstrb,
  input  wire  logic                s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire  logic                s_axi_bready,
  input  wire  logic [3:0]          s_axi_araddr,
  input  wire  logic                s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire  logic                s_axi_rready
);

  // ----------------------------------------
  // constants
  // ----------------------------------------
  localparam logic signed [W-1:0] SMAX = {1'b0, {(W-1){1'b1}}};
  localparam logic signed [W-1:0] SMIN = {1'b1, {(W-1){1'b0}}};

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // negation saturates so the most negative code does not wrap to itself
  function automatic logic signed [W-1:0] neg_sat(input logic signed [W-1:0] x);
    if (x == SMIN) begin
      neg_sat = SMAX;
    end else begin
      neg_sat = -x;
    end
  endfunction : neg_sat

  // keeps only the positive half of a sample, negative reads as zero
  function automatic logic [W-1:0] pos_part(input logic signed [W-1:0] x);
    if (x[W-1]) begin
      pos_part = '0;
    end else begin
      pos_part = x;
    end
  endfunction : pos_part

  function automatic logic [W-1:0] mag(input logic signed [W-1:0] x);
    if (x[W-1]) begin
      mag = neg_sat(x);
    end else begin
      mag = x;
    end
  endfunction : mag

  // ----------------------------------------
  // sign pin synchronisers
  // ----------------------------------------
  // only the second flop of each pair feeds logic
  logic spd_sign_meta_q;
  logic spd_sign_q;
  logic trq_sign_meta_q;
  logic trq_sign_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      spd_sign_meta_q <= 1'b0;
      spd_sign_q      <= 1'b0;
    end else if (ce) begin
      spd_sign_meta_q <= speed_sign_in;
      spd_sign_q      <= spd_sign_meta_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trq_sign_meta_q <= 1'b0;
      trq_sign_q      <= 1'b0;
    end else if (ce) begin
      trq_sign_meta_q <= torque_sign_in;
      trq_sign_q      <= trq_sign_meta_q;
    end
  end

  // sign pins act three edges after they move, samples after one
  wire speed_sign_s  = spd_sign_q;
  wire torque_sign_s = trq_sign_q;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  acs_cfg_s        cfg_q;
  logic [31:0]     tlim_par_q;
  logic [W-1:0]    int_speed_q;
  logic [W-1:0]    spl_par_q;

  // ----------------------------------------
  // torque limit selection
  // ----------------------------------------
  wire [W-1:0] tl_par_pos = tlim_par_q[`ACS_HALF_LO +: W];
  wire [W-1:0] tl_par_neg = tlim_par_q[`ACS_HALF_HI +: W];
  // analog readings of the two limit inputs, one per range
  wire [W-1:0] tl_pos_ana = pos_part(pos_torque_limit_in);
  wire [W-1:0] tl_neg_bip = mag(neg_torque_limit_in[W-1] ? neg_torque_limit_in : '0);
  wire [W-1:0] tl_neg_uni = pos_part(neg_torque_limit_in);
  logic [W-1:0] tl_pos_d;
  logic [W-1:0] tl_neg_d;

  always_comb begin
    case (cfg_q.torque_limit_input_mode)
      ACS_TL_ANA_BIPOLAR: begin
        tl_pos_d = tl_pos_ana;
        tl_neg_d = tl_neg_bip;
      end
      ACS_TL_ANA_UNIPOL: begin
        tl_pos_d = tl_pos_ana;
        tl_neg_d = tl_neg_uni;
      end
      ACS_TL_ANA_SHARED: begin
        tl_pos_d = tl_pos_ana;
        tl_neg_d = tl_pos_ana;
      end
      ACS_TL_PAR_1, ACS_TL_PAR_2, ACS_TL_PAR_3, ACS_TL_PAR_6: begin
        tl_pos_d = tl_par_pos;
        tl_neg_d = tl_par_neg;
      end
      // undefined code falls back to the parameter limits, the safer side
      default: begin
        tl_pos_d = tl_par_pos;
        tl_neg_d = tl_par_neg;
      end
    endcase
  end

  // ----------------------------------------
  // speed command
  // ----------------------------------------
  wire                 spd_ana   = (cfg_q.internal_external_speed_sel == 2'h0);
  wire signed [W-1:0]  spd_src   = spd_ana ? speed_cmd_analog_in : int_speed_q;
  wire [W-1:0]         spd_mag   = mag(spd_src);
  wire signed [W-1:0]  spd_pol   = cfg_q.speed_input_invert ? neg_sat(spd_src) : spd_src;
  wire signed [W-1:0]  spd_pin   = speed_sign_s ? neg_sat(spd_mag) : spd_mag;
  // internal speeds carry their own sign, so pin steering applies to analog only
  wire signed [W-1:0]  speed_d   = !spd_ana ? int_speed_q :
                                   cfg_q.speed_direction_sel ? spd_pin : spd_pol;

  // ----------------------------------------
  // torque command
  // ----------------------------------------
  wire signed [W-1:0]  trq_src   = cfg_q.torque_cmd_input_sel ? pos_torque_limit_in
                                                              : torque_cmd_analog_in;
  wire [W-1:0]         trq_mag   = mag(trq_src);
  wire signed [W-1:0]  trq_pol   = cfg_q.torque_input_invert ? neg_sat(trq_src) : trq_src;
  wire signed [W-1:0]  trq_pin   = torque_sign_s ? neg_sat(trq_mag) : trq_mag;
  wire signed [W-1:0]  torque_d  = cfg_q.torque_direction_sel ? trq_pin : trq_pol;

  // ----------------------------------------
  // speed limit
  // ----------------------------------------
  // limit is a magnitude, so either polarity of the voltage is accepted
  wire [W-1:0]         spl_d     = cfg_q.torque_cmd_sel ? mag(speed_limit_analog_in)
                                                        : spl_par_q;

  // ----------------------------------------
  // output registers
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pos_torque_limit  <= '0;
      neg_torque_limit  <= '0;
      speed_cmd         <= '0;
      torque_cmd        <= '0;
      speed_limit       <= '0;
      speed_from_analog <= 1'b0;
    end else if (ce) begin
      pos_torque_limit  <= tl_pos_d;
      neg_torque_limit  <= tl_neg_d;
      speed_cmd         <= speed_d;
      torque_cmd        <= torque_d;
      speed_limit       <= spl_d;
      speed_from_analog <= spd_ana;
    end
  end

  // ----------------------------------------
  // axi4-lite write path
  // ----------------------------------------
  // address and data are taken together; a lone one waits for its partner
  wire         wr_go    = ce & s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  wire [1:0]   wr_idx_hi = s_axi_awaddr[3:2];
  wire [3:0]   wr_idx   = {2'h0, wr_idx_hi};
  wire         wr_cfg   = wr_idx == `ACS_OFS_CFG;
  wire         wr_tlim  = wr_idx == `ACS_OFS_TLIM_PAR;
  wire         wr_ispd  = wr_idx == `ACS_OFS_INT_SPEED;
  wire         wr_spl   = wr_idx == `ACS_OFS_SPL_PAR;

  // ----------------------------------------
  // byte lane merge
  // ----------------------------------------
  // writable words sit in the first four slots, so every index there maps
  wire [31:0]  wmask    = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                           {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
  wire [31:0]  cfg_old  = {{(32-`ACS_CFG_BITS){1'b0}}, cfg_q};
  wire [31:0]  cfg_new  = (cfg_old & ~wmask) | (s_axi_wdata & wmask);
  wire [31:0]  tlim_new = (tlim_par_q & ~wmask) | (s_axi_wdata & wmask);
  wire [31:0]  ispd_old = {{(32-W){1'b0}}, int_speed_q};
  wire [31:0]  ispd_new = (ispd_old & ~wmask) | (s_axi_wdata & wmask);
  wire [31:0]  spl_old  = {{(32-W){1'b0}}, spl_par_q};
  wire [31:0]  spl_new  = (spl_old & ~wmask) | (s_axi_wdata & wmask);
  wire         wr_map   = wr_cfg | wr_tlim | wr_ispd | wr_spl;

  // ----------------------------------------
  // write handshake
  // ----------------------------------------
  // ready stays low while halted so nothing lands in frozen state
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;

  // ----------------------------------------
  // register write
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_q       <= acs_cfg_s'(`ACS_RST_CFG);
      tlim_par_q  <= `ACS_RST_TLIM_PAR;
      int_speed_q <= `ACS_RST_INT_SPEED;
      spl_par_q   <= `ACS_RST_SPL_PAR;
    end else if (wr_go) begin
      if (wr_cfg) begin
        cfg_q <= acs_cfg_s'(cfg_new[`ACS_CFG_BITS-1:0]);
      end
      if (wr_tlim) begin
        tlim_par_q <= tlim_new;
      end
      if (wr_ispd) begin
        int_speed_q <= ispd_new[W-1:0];
      end
      if (wr_spl) begin
        spl_par_q <= spl_new[W-1:0];
      end
    end
  end

  // ----------------------------------------
  // write answer
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `ACS_RESP_OKAY;
    end else if (ce) begin
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_map ? `ACS_RESP_OKAY : `ACS_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // axi4-lite read path
  // ----------------------------------------
  wire         rd_go   = ce & s_axi_arvalid & ~s_axi_rvalid;
  logic [31:0] rd_data;
  logic        rd_map;

  // ----------------------------------------
  // read data select
  // ----------------------------------------
  // a four-bit address reaches only the four writable words
  wire [3:0]   rd_word = {2'h0, s_axi_araddr[3:2]};

  always_comb begin
    rd_map  = 1'b1;
    rd_data = 32'h0000_0000;
    case (rd_word)
      `ACS_OFS_CFG:       rd_data = cfg_old;
      `ACS_OFS_TLIM_PAR:  rd_data = tlim_par_q;
      `ACS_OFS_INT_SPEED: rd_data = ispd_old;
      `ACS_OFS_SPL_PAR:   rd_data = spl_old;
      default: begin
        rd_map  = 1'b0;
        rd_data = 32'h0000_0000;
      end
    endcase
  end

  assign s_axi_arready = rd_go;

  // ----------------------------------------
  // read answer
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `ACS_RESP_OKAY;
    end else if (ce) begin
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_data;
        s_axi_rresp  <= rd_map ? `ACS_RESP_OKAY : `ACS_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule : acs_analog_cmd_sel

// *** hdl/acs_params.svh ***
// offsets, field positions, reset values of the analog command selector
`ifndef ACS_PARAMS_SVH
`define ACS_PARAMS_SVH

// ----------------------------------------
// register word indexes
// ----------------------------------------
`define ACS_OFS_CFG       4'h0
`define ACS_OFS_TLIM_PAR  4'h1
`define ACS_OFS_INT_SPEED 4'h2
`define ACS_OFS_SPL_PAR   4'h3
`define ACS_OFS_TLIM_STAT 4'h4
`define ACS_OFS_CMD_STAT  4'h5
`define ACS_OFS_SPL_STAT  4'h6

// ----------------------------------------
// field positions and widths
// ----------------------------------------
`define ACS_CFG_BITS      11
`define ACS_HALF_LO       0
`define ACS_HALF_HI       16
`define ACS_STAT_SSIGN    16
`define ACS_STAT_TSIGN    17

// ----------------------------------------
// reset values
// ----------------------------------------
`define ACS_RST_CFG       11'h000
`define ACS_RST_TLIM_PAR  32'h7fff_7fff
`define ACS_RST_INT_SPEED 16'h0000
`define ACS_RST_SPL_PAR   16'h7fff

// ----------------------------------------
// bus answers
// ----------------------------------------
`define ACS_RESP_OKAY     2'h0
`define ACS_RESP_SLVERR   2'h2

`endif

// *** hdl/acs_pkg.sv ***
// types of the analog command selector
package acs_pkg;

  // ----------------------------------------
  // torque limit input modes
  // ----------------------------------------
  typedef enum logic [2:0] {
    ACS_TL_ANA_BIPOLAR = 3'b000,
    ACS_TL_PAR_1       = 3'b001,
    ACS_TL_PAR_2       = 3'b010,
    ACS_TL_PAR_3       = 3'b011,
    ACS_TL_ANA_UNIPOL  = 3'b100,
    ACS_TL_ANA_SHARED  = 3'b101,
    ACS_TL_PAR_6       = 3'b110,
    ACS_TL_RSVD        = 3'b111
  } acs_tl_mode_e;

  // ----------------------------------------
  // configuration word, msb first
  // ----------------------------------------
  typedef struct packed {
    acs_tl_mode_e torque_limit_input_mode;
    logic         torque_input_invert;
    logic         torque_cmd_input_sel;
    logic         torque_direction_sel;
    logic         torque_cmd_sel;
    logic         speed_input_invert;
    logic         speed_direction_sel;
    logic [1:0]   internal_external_speed_sel;
  } acs_cfg_s;

endpackage : acs_pkg

// *** testbench/acs_checker.sv ***
// port assertions for the analog command selector
`timescale 1ns/100ps
module acs_checker
  import acs_pkg::*;
#(parameter int W = 16) (
  input wire logic               aclk,
  input wire logic               aresetn,
  input wire logic               ce,
  input wire logic               s_axi_awvalid,
  input wire logic               s_axi_awready,
  input wire logic               s_axi_wvalid,
  input wire logic               s_axi_bvalid,
  input wire logic               s_axi_bready,
  input wire logic               s_axi_arvalid,
  input wire logic               s_axi_arready,
  input wire logic               s_axi_rvalid,
  input wire logic               s_axi_rready,
  input wire logic        [W-1:0] pos_torque_limit,
  input wire logic signed [W-1:0] speed_cmd
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_take; ce && s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid; endsequence
  sequence rd_take; ce && s_axi_arvalid && !s_axi_rvalid; endsequence
  AST_WR_ANSWER: assert property (wr_take |=> s_axi_bvalid)
    else $error("no write answer");
  AST_RD_ANSWER: assert property (rd_take |=> s_axi_rvalid)
    else $error("no read answer");
  AST_B_STANDS: assert property (s_axi_bvalid && !(s_axi_bready && ce) |=> s_axi_bvalid)
    else $error("write answer dropped");
  AST_R_DROP: assert property (s_axi_rvalid && s_axi_rready && ce |=> !s_axi_rvalid)
    else $error("read answer held");
  AST_LONE_AW: assert property (s_axi_awready |-> s_axi_awvalid && s_axi_wvalid)
    else $error("address taken alone");
  AST_CE_GATE: assert property (!ce |-> !s_axi_awready && !s_axi_arready)
    else $error("bus taken while halted");
  AST_FREEZE: assert property (!ce |=> $stable(speed_cmd) && $stable(pos_torque_limit))
    else $error("outputs moved while halted");
  AST_RST_OUT: assert property ($rose(aresetn) |-> speed_cmd == '0 && pos_torque_limit == '0)
    else $error("outputs not cleared");
endmodule : acs_checker

bind acs_analog_cmd_sel acs_checker #(.W(W)) u_acs_checker (.aclk(aclk), .aresetn(aresetn), .ce(ce),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .pos_torque_limit(pos_torque_limit), .speed_cmd(speed_cmd));

// *** testbench/acs_host_model.sv ***
// host side model: analog samples and sign pins
`timescale 1ns/100ps
module acs_host_model (
  input  wire logic        aclk,
  input  wire logic [79:0] ana_set,
  input  wire logic [1:0]  sgn_set,
  output logic      [79:0] ana,
  output logic      [1:0]  sgn
);
  // one edge of delay, like a converter output latch
  always_ff @(posedge aclk) ana <= ana_set;
  always_ff @(posedge aclk) sgn <= sgn_set;
endmodule : acs_host_model

// *** testbench/test_analog_command_selector.sv ***
// self-checking bench for the analog command selector
`timescale 1ns/100ps
module test_analog_command_selector
  import acs_pkg::*;
;
  logic             aclk = 1'b0, aresetn = 1'b0, ce = 1'b1;
  logic [4:0][15:0] ana_set = {16'hfbaa, 16'hfe00, 16'hfd00, 16'hf800, 16'h1000};
  logic [4:0][15:0] ana;
  logic [1:0]       sgn_set = 2'h0, sgn, bresp, rresp;
  logic [15:0]      pos_tl, neg_tl, spd, trq, lim;
  logic [3:0]       awaddr = '0, araddr = '0, wstrb = '0;
  logic [31:0]      wdata = '0, rdata;
  logic             awvalid = '0, wvalid = '0, bready = '0, arvalid = '0, rready = '0;
  logic             awready, wready, bvalid, arready, rvalid, from_ana;
  int               error_cnt = 0, total_checks = 0;

  acs_host_model u_host (.aclk(aclk), .ana_set(ana_set), .sgn_set(sgn_set), .ana(ana), .sgn(sgn));
  acs_analog_cmd_sel #(.W(16)) dut (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .pos_torque_limit_in(ana[0]), .neg_torque_limit_in(ana[1]), .speed_cmd_analog_in(ana[2]),
    .torque_cmd_analog_in(ana[3]), .speed_limit_analog_in(ana[4]), .speed_sign_in(sgn[0]),
    .torque_sign_in(sgn[1]), .pos_torque_limit(pos_tl), .neg_torque_limit(neg_tl), .speed_cmd(spd),
    .torque_cmd(trq), .speed_limit(lim), .speed_from_analog(from_ana), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  initial forever #12.5 aclk = ~aclk;

  // ----------------------------------------
  // bus cycles and compare
  // ----------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    do @(posedge aclk); while ((awready & wready) !== 1'b1);
    awvalid <= 1'b0;
    wvalid  <= 1'b0;
    // answer accepted one edge late so a waiting response is seen
    @(posedge aclk);
    bready  <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready  <= 1'b0;
    chk(bresp, 32'h0);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready  <= 1'b0;
    chk(rdata, e);
    chk(rresp, 32'h0);
  endtask : rd
  // six edges cover the model latch plus the sign pin synchroniser
  task automatic put(input acs_cfg_s c);
    wr(4'h0, {21'h0, c}, 4'hf);
    repeat (6) @(posedge aclk);
  endtask : put

  task automatic t_regs();
    rd(4'h0, 32'h0);
    rd(4'h4, 32'h7fff_7fff);
    rd(4'h8, 32'h0);
    rd(4'hc, 32'h7fff);
    wr(4'h8, 32'h0000_abcd, 4'h1);
    rd(4'h8, 32'h00cd);
  endtask : t_regs
  task automatic t_tlim();
    logic [15:0] ep, en;
    wr(4'h4, 32'h0222_0111, 4'hf);
    for (int m = 0; m < 8; m++) begin
      ep = (m == 0 || m == 4 || m == 5) ? 16'h1000 : 16'h0111;
      en = (m == 0) ? 16'h0800 : (m == 4) ? 16'h0 : (m == 5) ? 16'h1000 : 16'h0222;
      put({m[2:0], 3'h0, m[0], 4'h0});
      chk(pos_tl, ep);
      chk(neg_tl, en);
      chk(lim, m[0] ? 16'h0456 : 16'h7fff);
    end
  endtask : t_tlim
  task automatic t_dir();
    logic [44:0] t [7] = '{{11'h000, 2'h3, 32'hfd00_fe00}, {11'h088, 2'h0, 32'h0300_0200},
      {11'h0ac, 2'h0, 32'h0300_0200}, {11'h024, 2'h3, 32'hfd00_fe00}, {11'h040, 2'h0, 32'hfd00_1000},
      {11'h0c0, 2'h0, 32'hfd00_f000}, {11'h001, 2'h0, 32'h00cd_fe00}};
    for (int i = 0; i < 7; i++) begin
      sgn_set <= t[i][33:32];
      put(t[i][44:34]);
      chk(spd, t[i][31:16]);
      chk(trq, t[i][15:0]);
      chk(from_ana, t[i][35:34] == 2'h0);
    end
  endtask : t_dir
  task automatic t_rst();
    put(11'h0c0);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    chk(trq, 16'h0);
    rd(4'h0, 32'h0);
    rd(4'h4, 32'h7fff_7fff);
    rd(4'h8, 32'h0);
  endtask : t_rst
  task automatic t_ce();
    put(11'h000);
    ce         <= 1'b0;
    ana_set[2] <= 16'h0111;
    repeat (6) @(posedge aclk);
    chk(spd, 16'hfd00);
    ce <= 1'b1;
    repeat (6) @(posedge aclk);
    chk(spd, 16'h0111);
  endtask : t_ce

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : print_verdict

  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_tlim();
    t_dir();
    t_rst();
    t_ce();
    print_verdict();
  end
  // the whole run needs a few hundred edges
  initial begin
    repeat (5000) @(posedge aclk);
    error_cnt++;
    print_verdict();
  end
endmodule : test_analog_command_selector
